/* hw/adcm_pkg.sv */
/*
 * Constants, types and helpers shared by the converter control block.
 * Assumes one 50 MHz system clock with a synchronous active-high reset.
 */
// ************************************************************
// Overview of operation
// - select codes 01..10 pick inputs 0..15, code 11 the internal source
// - stop input high powers down the converter; low leaves it running
// - end-of-conversion rises when done; result is valid from that edge
// - each result is a 12-bit parallel word
// - single mode converts once per trigger, then waits for the next
// - continuous mode restarts conversions without triggers until left
// - one channel, or a scanned ordered sequence stepping the select
// - watchdog flags any result outside the programmed low/high window
// - converter clock is derived from the system clock
// - result and end flag arrive 13 converter clocks after start
// - acquisition takes the first converter clock of a conversion
// ************************************************************
package adcm_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned SYS_CLK_HZ      = 50_000_000;
	localparam int unsigned TEMP_SAMPLE_NS  = 10_000;
	localparam int unsigned TEMP_SAMPLE_CYC = (TEMP_SAMPLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0]  CONV_TICKS      = 4'hD;
	localparam logic [3:0]  ACQ_TICKS       = 4'h1;

	// ************************************************************
	// channel codes
	// ************************************************************
	localparam logic [4:0] CH_EXT_FIRST = 5'h01;
	localparam logic [4:0] CH_EXT_LAST  = 5'h10;
	localparam logic [4:0] CH_INTERNAL  = 5'h11;

	// ************************************************************
	// register map, fields, reset values
	// ************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SEQ    = 8'h04;
	localparam logic [7:0] REG_CLKDIV = 8'h08;
	localparam logic [7:0] REG_WDG    = 8'h0C;
	localparam logic [7:0] REG_RESULT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_MASK   = 8'h18;
	localparam logic [7:0] REG_STATE  = 8'h1C;

	localparam int unsigned CTRL_CONT  = 0;
	localparam int unsigned CTRL_SCAN  = 1;
	localparam int unsigned CTRL_DISC  = 2;
	localparam int unsigned CTRL_START = 3;
	localparam int unsigned CTRL_DLEN  = 4;
	localparam int unsigned SEQ_FIRST  = 0;
	localparam int unsigned SEQ_LAST   = 8;
	localparam int unsigned WDG_LOW    = 0;
	localparam int unsigned WDG_HIGH   = 16;
	localparam int unsigned RES_CH     = 16;
	localparam int unsigned ST_EOC     = 0;
	localparam int unsigned ST_WDG     = 1;
	localparam int unsigned ST_SEQ     = 2;

	localparam logic [7:0]  CLKDIV_RST   = 8'h03;
	localparam logic [11:0] WDG_LOW_RST  = 12'h000;
	localparam logic [11:0] WDG_HIGH_RST = 12'hFFF;

	// ************************************************************
	// types and helpers
	// ************************************************************
	typedef enum logic [1:0] {CV_IDLE, CV_ACQ, CV_CONV} adcm_cv_state_t;
	typedef enum logic [0:0] {SQ_IDLE, SQ_BUSY} adcm_sq_state_t;

	// legal select codes run from the first external input to the internal one
	function automatic logic valid_channel(input logic [4:0] ch);
		return (ch >= CH_EXT_FIRST) && (ch <= CH_INTERNAL);
	endfunction

endpackage

/* hw/adcm_conv.sv */
/*
 * Converter core: acquisition and conversion timing, result and end flag.
 * Assumes tick_i is a one-cycle strobe per converter clock from the divider.
 */
`timescale 1ns/10ps
module adcm_conv
	import adcm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// control
	input  wire logic        tick_i,
	input  wire logic        start_i,
	input  wire logic        halt_i,
	input  wire logic [11:0] sample_i,
	// result
	output logic             busy_o,
	output logic             eoc_o,
	output logic [11:0]      result_o
);
	import adcm_pkg::*;

	localparam logic [3:0] LAST_CNT = CONV_TICKS - ACQ_TICKS;

	typedef struct packed {
		adcm_cv_state_t state;
		logic [3:0]     cnt;
		logic [11:0]    sample;
		logic           eoc;
		logic [11:0]    result;
	} adcm_cv_st_t;

	adcm_cv_st_t s_r;
	adcm_cv_st_t s_nxt;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_nxt = s_r;
		if (halt_i) begin
			// power-down drops any conversion; the last result is kept
			s_nxt.state = CV_IDLE;
			s_nxt.eoc   = 1'b0;
		end else begin
			unique case (s_r.state)
				CV_IDLE: begin
					if (start_i) begin
						s_nxt.state = CV_ACQ;
						s_nxt.eoc   = 1'b0;
					end
				end
				CV_ACQ: begin
					if (tick_i) begin
						s_nxt.sample = sample_i;
						s_nxt.cnt    = ACQ_TICKS;
						s_nxt.state  = CV_CONV;
					end
				end
				CV_CONV: begin
					if (tick_i) begin
						if (s_r.cnt == LAST_CNT) begin
							s_nxt.result = s_r.sample;
							s_nxt.eoc    = 1'b1;
							s_nxt.state  = CV_IDLE;
						end else begin
							s_nxt.cnt = s_r.cnt + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '{CV_IDLE, 4'h0, 12'h000, 1'b0, 12'h000};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy_o   = (s_r.state != CV_IDLE);
	assign eoc_o    = s_r.eoc;
	assign result_o = s_r.result;

	// ************************************************************
	// checks
	// ************************************************************
	logic [4:0] ticks_seen_r;

	// converter clocks counted since the accepted start
	always_ff @(posedge clk_i) begin
		if (rst_i || (s_r.state == CV_IDLE && start_i)) begin
			ticks_seen_r <= 5'h00;
		end else if (busy_o && tick_i) begin
			ticks_seen_r <= ticks_seen_r + 5'h01;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_eoc_after_13;
		$rose(eoc_o) |-> (ticks_seen_r == {1'b0, CONV_TICKS});
	endproperty
	a_eoc_after_13: assert property (p_eoc_after_13)
		else $error("end flag not after 13 converter clocks");

	property p_acq_first;
		(s_r.state == CV_ACQ && tick_i && !halt_i) |=> (s_r.sample == $past(sample_i)) && busy_o;
	endproperty
	a_acq_first: assert property (p_acq_first)
		else $error("sample not taken in first converter clock");

	property p_halt_down;
		halt_i |=> !busy_o && !eoc_o;
	endproperty
	a_halt_down: assert property (p_halt_down)
		else $error("converter active after stop");

endmodule // adcm_conv

/* hw/adcm_top.sv */
/*
 * Converter control block: register port, clock divider, mode sequencer,
 * analog watchdog, interrupt, and the converter core.
 * Assumes select, enable, stop and trigger come from logic on SYS_CLK_I;
 * the sampled code from the analog front end is asynchronous.
 */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module adcm_top (
	// clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        SYS_RST_I,
	// register port
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [31:0] REG_RDATA_O,
	// converter control from on-chip logic
	input  wire logic [4:0]  INPUT_CHANNEL_SELECT_I,
	input  wire logic        CONV_ENABLE_N_I,
	input  wire logic        STOP_I,
	input  wire logic        TRIGGER_I,
	// analog front end
	input  wire logic [11:0] SAMPLE_CODE_I,
	// result side
	output logic      [11:0] CONVERSION_RESULT_O,
	output logic             END_OF_CONV_O,
	output logic      [4:0]  ACTIVE_CHANNEL_O,
	output logic             WATCHDOG_O,
	output logic             IRQ_O
);
	import adcm_pkg::*;

	typedef struct packed {
		adcm_sq_state_t state;
		logic [11:0]    smp_meta;
		logic [11:0]    smp_sync;
		logic [7:0]     div_cnt;
		logic [7:0]     clkdiv;
		logic           tick;
		logic           start;
		logic           cont;
		logic           scan;
		logic           disc;
		logic [2:0]     dlen;
		logic [2:0]     disc_left;
		logic [4:0]     seq_first;
		logic [4:0]     seq_last;
		logic [4:0]     cur_ch;
		logic [4:0]     resume_ch;
		logic [4:0]     res_ch;
		logic [11:0]    wdg_lo;
		logic [11:0]    wdg_hi;
		logic [11:0]    result;
		logic           eoc_d;
		logic           wdg_out;
		logic [2:0]     status;
		logic [2:0]     mask;
		logic [31:0]    rdata;
	} adcm_top_st_t;

	adcm_top_st_t s_r;
	adcm_top_st_t s_nxt;
	logic         conv_busy;
	logic         conv_eoc;
	logic [11:0]  conv_result;
	logic         halt;
	logic         eoc_rise;

	// enable is active low; either one holds the converter down
	assign halt     = STOP_I | CONV_ENABLE_N_I;
	assign eoc_rise = conv_eoc & ~s_r.eoc_d;

	// ************************************************************
	// converter core
	// ************************************************************
	adcm_conv u_conv (
		.clk_i    (SYS_CLK_I),
		.rst_i    (SYS_RST_I),
		.tick_i   (s_r.tick),
		.start_i  (s_r.start),
		.halt_i   (halt),
		.sample_i (s_r.smp_sync),
		.busy_o   (conv_busy),
		.eoc_o    (conv_eoc),
		.result_o (conv_result)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic       wr_ctrl;
		logic       trig;
		logic       last;
		logic       outside;
		logic [4:0] first_ch;
		logic [4:0] step_ch;
		logic [4:0] top_ch;
		logic [2:0] set;
		logic [2:0] clr;
		wr_ctrl  = REG_WR_I && (REG_ADDR_I == REG_CTRL);
		trig     = TRIGGER_I | (wr_ctrl & REG_WDATA_I[CTRL_START]);
		step_ch  = s_r.cur_ch + 5'h01;
		top_ch   = s_r.scan ? s_r.seq_first : INPUT_CHANNEL_SELECT_I;
		first_ch = (s_r.scan && s_r.disc) ? s_r.resume_ch : top_ch;
		last     = !s_r.scan || (s_r.cur_ch == s_r.seq_last) || !valid_channel(step_ch);
		outside  = (conv_result > s_r.wdg_hi) || (conv_result < s_r.wdg_lo);
		set      = 3'h0;
		clr      = 3'h0;

		s_nxt       = s_r;
		s_nxt.start = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		s_nxt.eoc_d = conv_eoc;
		// two flops before anything looks at the front-end code
		s_nxt.smp_meta = SAMPLE_CODE_I;
		s_nxt.smp_sync = s_r.smp_meta;

		// converter clock is a strobe off the system clock, not a free source;
		// >= so that lowering the divisor mid-count does not wrap the counter
		if (s_r.div_cnt >= s_r.clkdiv) begin
			s_nxt.div_cnt = 8'h00;
			s_nxt.tick    = 1'b1;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt + 8'h01;
			s_nxt.tick    = 1'b0;
		end

		// mode sequencer
		unique case (s_r.state)
			SQ_IDLE: begin
				// an illegal select code leaves the trigger without effect
				if (trig && !halt && valid_channel(first_ch)) begin
					s_nxt.start     = 1'b1;
					s_nxt.cur_ch    = first_ch;
					s_nxt.disc_left = s_r.dlen;
					s_nxt.state     = SQ_BUSY;
				end
			end
			SQ_BUSY: begin
				if (halt) begin
					s_nxt.state = SQ_IDLE;
				end else if (eoc_rise) begin
					s_nxt.result  = conv_result;
					s_nxt.res_ch  = s_r.cur_ch;
					s_nxt.wdg_out = outside;
					set[ST_EOC]   = 1'b1;
					set[ST_WDG]   = outside;
					if (!last && !(s_r.disc && s_r.disc_left == 3'h0)) begin
						// step the select to the next channel of the scan
						s_nxt.start     = 1'b1;
						s_nxt.cur_ch    = step_ch;
						s_nxt.disc_left = s_r.disc_left - 3'h1;
					end else if (!last) begin
						// discontinuous group done; resume here on next trigger
						s_nxt.resume_ch = step_ch;
						s_nxt.state     = SQ_IDLE;
					end else begin
						set[ST_SEQ]     = s_r.scan;
						s_nxt.resume_ch = s_r.seq_first;
						if (s_r.cont && valid_channel(top_ch)) begin
							s_nxt.start     = 1'b1;
							s_nxt.cur_ch    = top_ch;
							s_nxt.disc_left = s_r.dlen;
						end else begin
							s_nxt.state = SQ_IDLE;
						end
					end
				end
			end
		endcase

		// register writes
		if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				REG_CTRL: begin
					s_nxt.cont = REG_WDATA_I[CTRL_CONT];
					s_nxt.scan = REG_WDATA_I[CTRL_SCAN];
					s_nxt.disc = REG_WDATA_I[CTRL_DISC];
					s_nxt.dlen = REG_WDATA_I[CTRL_DLEN +: 3];
				end
				REG_SEQ: begin
					s_nxt.seq_first = REG_WDATA_I[SEQ_FIRST +: 5];
					s_nxt.seq_last  = REG_WDATA_I[SEQ_LAST +: 5];
					s_nxt.resume_ch = REG_WDATA_I[SEQ_FIRST +: 5];
				end
				REG_CLKDIV: s_nxt.clkdiv = REG_WDATA_I[7:0];
				REG_WDG: begin
					s_nxt.wdg_lo = REG_WDATA_I[WDG_LOW +: 12];
					s_nxt.wdg_hi = REG_WDATA_I[WDG_HIGH +: 12];
				end
				REG_STATUS: clr = REG_WDATA_I[2:0];
				REG_MASK:   s_nxt.mask = REG_WDATA_I[2:0];
				default: ;
			endcase
		end
		// a new event wins over a write-one-to-clear in the same cycle
		s_nxt.status = (s_r.status & ~clr) | set;

		// register reads; data stand only in the following cycle
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				REG_CTRL:   s_nxt.rdata = {25'h0, s_r.dlen, 1'b0, s_r.disc, s_r.scan, s_r.cont};
				REG_SEQ:    s_nxt.rdata = {19'h0, s_r.seq_last, 3'h0, s_r.seq_first};
				REG_CLKDIV: s_nxt.rdata = {24'h0, s_r.clkdiv};
				REG_WDG:    s_nxt.rdata = {4'h0, s_r.wdg_hi, 4'h0, s_r.wdg_lo};
				REG_RESULT: s_nxt.rdata = {11'h0, s_r.res_ch, 4'h0, s_r.result};
				REG_STATUS: s_nxt.rdata = {29'h0, s_r.status};
				REG_MASK:   s_nxt.rdata = {29'h0, s_r.mask};
				REG_STATE:  s_nxt.rdata = {29'h0, halt, conv_busy, s_r.state == SQ_BUSY};
				default:    s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			s_r           <= '0;
			s_r.state     <= SQ_IDLE;
			s_r.clkdiv    <= CLKDIV_RST;
			s_r.seq_first <= CH_EXT_FIRST;
			s_r.seq_last  <= CH_EXT_LAST;
			s_r.resume_ch <= CH_EXT_FIRST;
			s_r.wdg_lo    <= WDG_LOW_RST;
			s_r.wdg_hi    <= WDG_HIGH_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign REG_RDATA_O         = s_r.rdata;
	assign CONVERSION_RESULT_O = conv_result;
	assign END_OF_CONV_O       = conv_eoc;
	assign ACTIVE_CHANNEL_O    = s_r.cur_ch;
	assign WATCHDOG_O          = s_r.wdg_out;
	assign IRQ_O               = |(s_r.status & s_r.mask);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	property p_sel_legal;
		s_r.start |-> valid_channel(ACTIVE_CHANNEL_O) && (ACTIVE_CHANNEL_O <= CH_INTERNAL);
	endproperty
	a_sel_legal: assert property (p_sel_legal)
		else $error("conversion started on illegal select code");

	property p_stop;
		STOP_I |=> (s_r.state == SQ_IDLE) && !conv_busy;
	endproperty
	a_stop: assert property (p_stop)
		else $error("activity after stop");

	property p_result_hold;
		END_OF_CONV_O && $past(END_OF_CONV_O) |-> $stable(CONVERSION_RESULT_O);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result moved while end flag high");

	property p_result_reg;
		(eoc_rise && s_r.state == SQ_BUSY && !halt) |=> (s_r.result == $past(conv_result));
	endproperty
	a_result_reg: assert property (p_result_reg)
		else $error("result word not captured");

	property p_single;
		(eoc_rise && s_r.state == SQ_BUSY && !halt && !s_r.cont && !s_r.scan)
			|=> (s_r.state == SQ_IDLE) && !s_r.start;
	endproperty
	a_single: assert property (p_single)
		else $error("single mode did not stop after one conversion");

	property p_cont;
		(eoc_rise && s_r.state == SQ_BUSY && !halt && s_r.cont && !s_r.scan
			&& valid_channel(INPUT_CHANNEL_SELECT_I)) |=> s_r.start ##1 conv_busy;
	endproperty
	a_cont: assert property (p_cont)
		else $error("continuous mode did not restart");

	property p_scan_step;
		(eoc_rise && s_r.state == SQ_BUSY && !halt && s_r.scan && !s_r.disc
			&& s_r.cur_ch != s_r.seq_last && s_r.cur_ch < CH_INTERNAL)
			|=> s_r.start && (s_r.cur_ch == $past(s_r.cur_ch) + 5'h01);
	endproperty
	a_scan_step: assert property (p_scan_step)
		else $error("scan did not step the select");

	property p_wdg;
		(eoc_rise && s_r.state == SQ_BUSY && !halt && (conv_result > s_r.wdg_hi))
			|=> s_r.status[ST_WDG] && WATCHDOG_O;
	endproperty
	a_wdg: assert property (p_wdg)
		else $error("watchdog missed result above high threshold");

	property p_wdg_low;
		(eoc_rise && s_r.state == SQ_BUSY && !halt && (conv_result < s_r.wdg_lo))
			|=> s_r.status[ST_WDG] && WATCHDOG_O;
	endproperty
	a_wdg_low: assert property (p_wdg_low)
		else $error("watchdog missed result below low threshold");

	// a result inside the window must drop the watchdog level again
	property p_wdg_inside;
		(eoc_rise && s_r.state == SQ_BUSY && !halt
			&& (conv_result <= s_r.wdg_hi) && (conv_result >= s_r.wdg_lo))
			|=> !WATCHDOG_O;
	endproperty
	a_wdg_inside: assert property (p_wdg_inside)
		else $error("watchdog set for result inside window");

	// a trigger that arrives mid-conversion is dropped, not queued
	property p_busy_trig;
		(s_r.state == SQ_BUSY && TRIGGER_I && !eoc_rise) |=> !s_r.start;
	endproperty
	a_busy_trig: assert property (p_busy_trig)
		else $error("trigger taken while busy");

	// a discontinuous group stops after its last member until the next trigger
	property p_disc_pause;
		(eoc_rise && s_r.state == SQ_BUSY && !halt && s_r.scan && s_r.disc
			&& !s_r.cont && s_r.disc_left == 3'h0)
			|=> (s_r.state == SQ_IDLE) && !s_r.start;
	endproperty
	a_disc_pause: assert property (p_disc_pause)
		else $error("discontinuous group ran past its length");

	// the enable pin high acts like stop
	property p_enb_off;
		CONV_ENABLE_N_I |=> (s_r.state == SQ_IDLE) && !conv_busy;
	endproperty
	a_enb_off: assert property (p_enb_off)
		else $error("activity while enable is high");

	// the divider never gives two strobes in a row unless it divides by one
	property p_tick_gap;
		(s_r.tick && s_r.clkdiv != 8'h00) |=> !s_r.tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("converter clock strobe too fast");

	c_single: cover property (eoc_rise && !s_r.cont && !s_r.scan);
	c_scan_end: cover property (eoc_rise && s_r.scan && s_r.cur_ch == s_r.seq_last);
	c_wdg_irq: cover property (IRQ_O && s_r.status[ST_WDG]);
	c_cont_restart: cover property (eoc_rise && s_r.cont && !halt);
	c_disc_pause: cover property (eoc_rise && s_r.scan && s_r.disc && s_r.disc_left == 3'h0);

endmodule // adcm_top

/* tb/adcm_ctl_model.sv */
/*
 * Model of the on-chip control logic and analog front end that feed the
 * converter block. Assumes commands from the bench on the same clock.
 */
`timescale 1ns/10ps
module adcm_ctl_model
	import adcm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// commands from the bench
	input  wire logic        go_i,
	input  wire logic        halt_i,
	input  wire logic        off_i,
	input  wire logic [4:0]  ch_i,
	input  wire logic [11:0] code_i,
	// lines toward the converter
	output logic      [4:0]  sel_o = 5'h01,
	output logic             enb_n_o = 1'b0,
	output logic             stop_o = 1'b0,
	output logic             trig_o = 1'b0,
	output logic      [11:0] sample_o = 12'h000
);
	// ********
	// control lines
	// ********
	logic        pend_r = 1'b0;
	int unsigned settle_r = 0;

	// triggers wait while the temperature source settles, so they may come late
	always @(posedge clk_i) begin
		sel_o <= ch_i;
		stop_o <= halt_i;
		enb_n_o <= off_i;
		sample_o <= code_i; // held stable across the whole conversion
		trig_o <= 1'b0;
		if (rst_i) begin
			pend_r <= 1'b0;
			settle_r <= 0;
		end else begin
			settle_r <= (ch_i != sel_o) ? 0 : settle_r + 1;
			if (go_i) begin
				pend_r <= 1'b1;
			end else if (pend_r && (sel_o != CH_INTERNAL || settle_r >= TEMP_SAMPLE_CYC)) begin
				trig_o <= 1'b1;
				pend_r <= 1'b0;
			end
		end
	end
endmodule // adcm_ctl_model

/* tb/adcm_top_tb.sv */
/*
 * Self-checking bench for the converter control block with a reference
 * model of results. Assumes one 50 MHz clock and synchronous reset.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module adcm_top_tb;
	import adcm_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic        go = 1'b0, halt = 1'b0, off = 1'b0, eoc_q = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wd = 32'h0, rdata;
	logic [4:0]  ch = 5'h01, sel, act;
	logic [11:0] code = 12'h000, samp, res, exp_code = 12'h000;
	logic        enb_n, stp, trig, eoc, wdg, irq;
	int          n_mismatch = 0, checks_done = 0, seed = 6;
	int          cyc = 0, t_trig = 0, n_eoc = 0, lat = 0;
	logic [4:0]  exp_ch[$], exp_act;
	logic [11:0] wv[4] = '{12'h0FF, 12'h100, 12'h800, 12'h801};
	logic        wb[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic [4:0]  chs[5] = '{5'h01, 5'h10, 5'h11, 5'h00, 5'h12};

	always #10 clk = ~clk;

	adcm_ctl_model ctl (.clk_i(clk), .rst_i(rst), .go_i(go), .halt_i(halt), .off_i(off),
		.ch_i(ch), .code_i(code), .sel_o(sel), .enb_n_o(enb_n), .stop_o(stp),
		.trig_o(trig), .sample_o(samp));
	adcm_top uut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .INPUT_CHANNEL_SELECT_I(sel),
		.CONV_ENABLE_N_I(enb_n), .STOP_I(stp), .TRIGGER_I(trig), .SAMPLE_CODE_I(samp),
		.CONVERSION_RESULT_O(res), .END_OF_CONV_O(eoc), .ACTIVE_CHANNEL_O(act),
		.WATCHDOG_O(wdg), .IRQ_O(irq));

	// ********
	// reference model: every end-of-conversion edge is checked
	// ********
	always @(posedge clk) begin
		cyc <= cyc + 1;
		eoc_q <= eoc;
		if (trig) t_trig <= cyc;
		if (eoc && !eoc_q) begin
			n_eoc <= n_eoc + 1;
			lat <= cyc - t_trig;
			`CHK(res, exp_code)
			// pop once: the compare macro evaluates its operands twice on a mismatch
			if (exp_ch.size() > 0) begin
				exp_act = exp_ch.pop_front();
				`CHK(act, exp_act)
			end
		end
	end

	// ********
	// bus and stimulus tasks
	// ********
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		`CHK(rdata, e)
	endtask

	task automatic pulse;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask

	// m: 0 plain, 1 retrigger while busy, 2 stop mid-way, 3 disable mid-way
	task automatic conv(input logic [4:0] c, input logic [11:0] v, input int n, input int m);
		int k;
		k = n_eoc + n;
		ch <= c;
		code <= v;
		if (m < 2) exp_code = v;
		repeat (3) @(posedge clk);
		pulse();
		if (m == 1) begin
			repeat (4) @(posedge clk);
			pulse();
		end
		if (m >= 2) begin
			repeat (6) @(posedge clk);
			halt <= (m == 2);
			off <= (m == 3);
		end
		for (int i = 0; i < 800 && n_eoc < k; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		`CHK(n_eoc, k)
		if (m >= 2) `CHK(eoc, 1'b0)
		if (m >= 2) rd_chk(REG_STATE, 32'h4);
		halt <= 1'b0;
		off <= 1'b0;
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard, far beyond the expected run length
	initial begin
		#(20 * 40000);
		n_mismatch++;
		finish_test();
	end

	// ********
	// main sequence
	// ********
	initial begin
		int k;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_chk(REG_CLKDIV, 32'h3);
		rd_chk(REG_SEQ, 32'h1001);
		rd_chk(REG_WDG, 32'h0FFF_0000);
		rd_chk(8'h20, 32'h0);
		wr_reg(REG_CLKDIV, 32'h0);
		rd_chk(REG_CLKDIV, 32'h0);
		$display("registers done");
		// boundary codes convert, illegal codes are ignored
		for (int i = 0; i < 5; i++) begin
			if (i < 3) exp_ch.push_back(chs[i]);
			conv(chs[i], 12'($random(seed)), (i < 3) ? 1 : 0, 0);
			if (i < 3) `CHK(lat, 15)
		end
		for (int i = 0; i < 3; i++) begin
			ch <= 5'($unsigned($random(seed)) % 16 + 1);
			@(posedge clk);
			exp_ch.push_back(ch);
			conv(ch, 12'($random(seed)), 1, 0);
		end
		// slower converter clock: 13 strobes four system clocks apart, free phase
		wr_reg(REG_CLKDIV, 32'h3);
		exp_ch.push_back(5'h07);
		conv(5'h07, 12'($random(seed)), 1, 0);
		`CHK(lat >= 51 && lat <= 54, 1'b1)
		wr_reg(REG_CLKDIV, 32'h0);
		exp_ch.push_back(5'h05);
		conv(5'h05, 12'h5A3, 1, 1);
		conv(5'h03, 12'h111, 0, 2);
		conv(5'h03, 12'h222, 0, 3);
		rd_chk(REG_RESULT, {11'h0, 5'h05, 4'h0, exp_code});
		$display("single mode done");
		wr_reg(REG_WDG, 32'h0800_0100);
		wr_reg(REG_MASK, 32'h2);
		rd_chk(REG_MASK, 32'h2);
		for (int i = 0; i < 4; i++) begin
			conv(5'h02, wv[i], 1, 0);
			`CHK(wdg, wb[i])
			`CHK(irq, wb[i])
			wr_reg(REG_STATUS, 32'h7);
		end
		wr_reg(REG_MASK, 32'h0);
		conv(5'h02, 12'h050, 1, 0);
		`CHK(irq, 1'b0)
		rd_chk(REG_STATUS, 32'h3);
		wr_reg(REG_STATUS, 32'h3);
		rd_chk(REG_STATUS, 32'h0);
		$display("watchdog done");
		wr_reg(REG_SEQ, 32'h0503);
		wr_reg(REG_CTRL, 32'h2);
		exp_ch = '{5'h03, 5'h04, 5'h05};
		conv(5'h01, 12'h3C3, 3, 0);
		rd_chk(REG_STATUS, 32'h5);
		wr_reg(REG_SEQ, 32'h0503);
		wr_reg(REG_CTRL, 32'h16);
		rd_chk(REG_CTRL, 32'h16);
		exp_ch = '{5'h03, 5'h04};
		conv(5'h01, 12'h0F0, 2, 0);
		exp_ch.push_back(5'h05);
		conv(5'h01, 12'h0F0, 1, 0);
		$display("scan done");
		k = n_eoc;
		wr_reg(REG_CTRL, 32'h9);
		repeat (100) @(posedge clk);
		`CHK(n_eoc >= k + 4, 1'b1)
		wr_reg(REG_CTRL, 32'h0);
		repeat (40) @(posedge clk);
		k = n_eoc;
		repeat (60) @(posedge clk);
		`CHK(n_eoc, k)
		$display("continuous done");
		finish_test();
	end
endmodule // adcm_top_tb
